/* File: hdl/dsau_consts.svh */
// Constants for the dual setpoint alarm unit: offsets, fields, limits, timing.
`ifndef DSAU_CONSTS_SVH
`define DSAU_CONSTS_SVH

// ==========================================================
// Register offsets
`define DSAU_CTRL0_OFS 8'h00
`define DSAU_CTRL1_OFS 8'h04
`define DSAU_SP0_OFS 8'h08
`define DSAU_SP1_OFS 8'h0C
`define DSAU_HYS0_OFS 8'h10
`define DSAU_HYS1_OFS 8'h14
`define DSAU_DLY0_OFS 8'h18
`define DSAU_DLY1_OFS 8'h1C
`define DSAU_SIL0_OFS 8'h20
`define DSAU_SIL1_OFS 8'h24
`define DSAU_STAT_OFS 8'h28
`define DSAU_DP_OFS 8'h2C
`define DSAU_CHAN_BIT 2

// ==========================================================
// Field positions
`define DSAU_EN_BIT 0
`define DSAU_TYPE_BIT 1
`define DSAU_HL_BIT 2
`define DSAU_NC_BIT 3
`define DSAU_CDP_LSB 8
`define DSAU_DP_W 3
`define DSAU_TDP_LSB 3
`define DSAU_STAT_W 5
`define DSAU_STAT1_LSB 8

// ==========================================================
// Widths, limits and default values
`define DSAU_SP_W 27
`define DSAU_RATE_W 20
`define DSAU_TIME_W 12
`define DSAU_RATE_MAX 32'h000F423F
`define DSAU_TOTAL_MAX 32'h05F5E0FF
`define DSAU_TIME_MAX 32'h00000E10
`define DSAU_DEF_SP 27'h0000000
`define DSAU_DEF_HYS 20'h00000
`define DSAU_DEF_TIME 12'h000
`define DSAU_DEF_HIGH 1'b1
`define DSAU_DEF_NC 1'b1

// ==========================================================
// Bus answers and timing
`define DSAU_RESP_OKAY 2'h0
`define DSAU_RESP_SLVERR 2'h2
`define DSAU_CLK_PERIOD_NS 50
`define DSAU_HALF_SEC_NS 500000000
`define DSAU_HALF_SEC_CYCLES (`DSAU_HALF_SEC_NS / `DSAU_CLK_PERIOD_NS)
`define DSAU_HALF_CNT_W 24

`endif

/* File: hdl/dsau_pkg.sv */
// Types shared by the dual setpoint alarm unit.
`include "dsau_consts.svh"

package dsau_pkg;

  typedef enum logic [1:0] {
    DSAU_IDLE = 2'h0,
    DSAU_DELAY = 2'h1,
    DSAU_ALARM = 2'h2,
    DSAU_SILENCE = 2'h3
  } dsau_state_type;

  typedef struct packed {
    logic alarm_enable;
    logic total_sel;
    logic high_low_select;
    logic nc_sel;
    logic [`DSAU_SP_W-1:0] setpoint;
    logic [`DSAU_RATE_W-1:0] hysteresis_band;
    logic [`DSAU_TIME_W-1:0] activation_delay;
    logic [`DSAU_TIME_W-1:0] silence_time;
  } dsau_cfg_type;

  typedef struct packed {
    logic condition;
    logic switch_closed;
    logic annunciator;
    dsau_state_type state;
  } dsau_stat_type;

endpackage

/* File: hdl/dsau_channel.sv */
// One alarm channel: comparison with hysteresis, delay and silence timing, outputs.
`timescale 1ns/100ps
`include "dsau_consts.svh"

module dsau_channel
  import dsau_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire dsau_cfg_type cfg,
  input wire logic [`DSAU_RATE_W-1:0] rate_value,
  input wire logic [`DSAU_SP_W-1:0] total_value,
  input wire logic sec_tick,
  input wire logic flash_phase,
  input wire logic accept_pulse,
  output dsau_stat_type stat
);

  logic cond_reg, cond_next;
  dsau_state_type state_reg, state_next;
  logic [`DSAU_TIME_W-1:0] cnt_reg, cnt_next;
  logic switch_reg, switch_next;
  logic annun_reg, annun_next;
  logic [`DSAU_SP_W:0] mon, hys, lo_bound, hi_bound;

  // ==========================================================
  // Alarm condition
  always_comb begin
    mon = cfg.total_sel ? {1'b0, total_value} : {8'h00, rate_value}; // see (R02)
    hys = cfg.total_sel ? '0 : {8'h00, cfg.hysteresis_band}; // see (R06) see (R07)
    lo_bound = ({1'b0, cfg.setpoint} > hys) ? ({1'b0, cfg.setpoint} - hys) : '0;
    hi_bound = {1'b0, cfg.setpoint} + hys;
    if (!cfg.alarm_enable) begin // see (R13)
      cond_next = 1'b0;
    end else if (cfg.high_low_select) begin
      // Releases only below setpoint minus band; a band above setpoint never releases.
      cond_next = cond_reg ? (mon >= lo_bound) : (mon >= {1'b0, cfg.setpoint}); // see (R03) see (R05)
    end else begin
      cond_next = cond_reg ? (mon <= hi_bound) : (mon <= {1'b0, cfg.setpoint}); // see (R03) see (R20)
    end
  end

  // ==========================================================
  // Delay and silence sequencing
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    unique case (state_reg)
      DSAU_IDLE: begin
        if (cond_reg) begin
          cnt_next = cfg.activation_delay;
          state_next = (cfg.activation_delay == `DSAU_DEF_TIME) ? DSAU_ALARM : DSAU_DELAY; // see (R08)
        end
      end
      DSAU_DELAY: begin
        // The count ends on a tick with zero left, so the wait is never short.
        if (!cond_reg) begin
          state_next = DSAU_IDLE; // see (R19)
        end else if (sec_tick) begin
          if (cnt_reg == `DSAU_DEF_TIME) begin
            state_next = DSAU_ALARM; // see (R09)
          end else begin
            cnt_next = cnt_reg - 1'b1;
          end
        end
      end
      DSAU_ALARM: begin
        if (!cond_reg) begin
          state_next = DSAU_IDLE;
        end else if (accept_pulse && cfg.silence_time != `DSAU_DEF_TIME) begin
          cnt_next = cfg.silence_time; // see (R18)
          state_next = DSAU_SILENCE; // see (R10)
        end
      end
      DSAU_SILENCE: begin
        if (!cond_reg) begin
          state_next = DSAU_IDLE;
        end else if (sec_tick) begin
          if (cnt_reg == `DSAU_DEF_TIME) begin
            state_next = DSAU_ALARM;
          end else begin
            cnt_next = cnt_reg - 1'b1;
          end
        end
      end
    endcase
    switch_next = cfg.nc_sel ^ (state_next == DSAU_ALARM); // see (R11)
    annun_next = (state_next == DSAU_ALARM) ||
                 ((state_next != DSAU_IDLE) && flash_phase); // see (R09) see (R10) see (R12)
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cond_reg <= 1'b0;
      state_reg <= DSAU_IDLE;
      cnt_reg <= `DSAU_DEF_TIME;
      switch_reg <= 1'b0;
      annun_reg <= 1'b0;
    end else begin
      cond_reg <= cond_next;
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      switch_reg <= switch_next;
      annun_reg <= annun_next;
    end
  end

  assign stat = '{condition: cond_reg, switch_closed: switch_reg,
                  annunciator: annun_reg, state: state_reg};

endmodule // dsau_channel

/* File: hdl/dsau_top.sv */
// Dual setpoint alarm unit: register file on AXI4-Lite, time base and two channels.
// Function
// (R01) Two independent channels, each high/low, rate/total and open/closed sense.
// (R02) Type selects rate or accumulated total as the compared quantity.
// (R03) Alarm on equality with setpoint; high also above, low also below.
// (R04) Total refreshed and compared twice per second; up to half second lag.
// (R05) High rate alarm with band holds until rate below setpoint minus band.
// (R06) Hysteresis band applies to rate channels only.
// (R07) Band is held in the same units as the rate value.
// (R08) Activation delay 0 to 3600 s in 1 s steps; zero acts at once.
// (R09) Annunciator flashes during delay; output alarms when delay expires.
// (R10) Accepted alarm releases output for silence time while annunciator flashes.
// (R11) Sense setting sets idle switch level; alarm drives the opposite.
// (R12) Annunciators always show the status of both channels.
// (R13) Enable turns a channel on or off keeping its other settings.
// (R14) Recalibration or a type change disables both channels.
// (R15) Type change loads default settings and disables that channel.
// (R16) Rate setpoints 0 to 999999, total setpoints 0 to 99999999.
// (R17) Setpoint decimal point follows the matching value's decimal point.
// (R18) Silence time 0 to 3600 s; nonzero makes accept acknowledge alarms.
// (R19) Condition clearing during delay cancels it; output stays idle.
// (R20) Low rate alarm with band holds until rate above setpoint plus band.
//
// Local design decisions: the register offsets and register access over AXI4-Lite.
`timescale 1ns/100ps
`include "dsau_consts.svh"

module dsau_top
  import dsau_pkg::*;
#(
  parameter int HALF_SEC_CYCLES = `DSAU_HALF_SEC_CYCLES
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [`DSAU_RATE_W-1:0] rate_value,
  input wire logic [`DSAU_SP_W-1:0] total_value,
  input wire logic recal_pulse,
  input wire logic accept_pulse,
  output logic [1:0] alarm_switch_closed,
  output logic [1:0] annunciator_on
);

  // ==========================================================
  // Helper functions
  function automatic logic [31:0] merge(input logic [31:0] old_w,
                                        input logic [31:0] new_w,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [31:0] clamp(input logic [31:0] v, input logic [31:0] lim);
    return (v > lim) ? lim : v;
  endfunction

  function automatic logic [31:0] ctrl_word(input dsau_cfg_type c);
    logic [31:0] w;
    w = '0;
    w[`DSAU_EN_BIT] = c.alarm_enable;
    w[`DSAU_TYPE_BIT] = c.total_sel;
    w[`DSAU_HL_BIT] = c.high_low_select;
    w[`DSAU_NC_BIT] = c.nc_sel;
    return w;
  endfunction

  function automatic dsau_cfg_type default_cfg(input logic total);
    dsau_cfg_type c;
    c.alarm_enable = 1'b0;
    c.total_sel = total;
    c.high_low_select = `DSAU_DEF_HIGH;
    c.nc_sel = `DSAU_DEF_NC;
    c.setpoint = `DSAU_DEF_SP;
    c.hysteresis_band = `DSAU_DEF_HYS;
    c.activation_delay = `DSAU_DEF_TIME;
    c.silence_time = `DSAU_DEF_TIME;
    return c;
  endfunction

  // ==========================================================
  // State
  dsau_cfg_type cfg_reg [2];
  dsau_cfg_type cfg_next [2];
  logic [2*`DSAU_DP_W-1:0] dp_reg, dp_next;
  logic aw_held_reg, aw_held_next;
  logic [7:0] awaddr_reg, awaddr_next;
  logic w_held_reg, w_held_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  logic [`DSAU_HALF_CNT_W-1:0] half_cnt_reg, half_cnt_next;
  logic flash_reg, flash_next;
  logic [`DSAU_SP_W-1:0] total_snap_reg, total_snap_next;
  logic half_tick, sec_tick, wr_fire, wch, rch, kill_all;
  logic [31:0] wv;
  logic [31:0] lim;
  logic [`DSAU_DP_W-1:0] cdp;
  dsau_stat_type stat_w [2];

  // ==========================================================
  // Time base
  always_comb begin
    half_tick = (half_cnt_reg == `DSAU_HALF_CNT_W'(HALF_SEC_CYCLES - 1));
    half_cnt_next = half_tick ? '0 : half_cnt_reg + 1'b1;
    flash_next = flash_reg ^ half_tick;
    sec_tick = half_tick & flash_reg;
    // The channels see a total that moves only on the half-second tick.
    total_snap_next = half_tick ? total_value : total_snap_reg; // see (R04)
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      half_cnt_reg <= '0;
      flash_reg <= 1'b0;
      total_snap_reg <= '0;
    end else begin
      half_cnt_reg <= half_cnt_next;
      flash_reg <= flash_next;
      total_snap_reg <= total_snap_next;
    end
  end

  // ==========================================================
  // Bus slave and register file
  assign s_axi_awready = !aw_held_reg;
  assign s_axi_wready = !w_held_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  always_comb begin
    cfg_next = cfg_reg;
    dp_next = dp_reg;
    aw_held_next = aw_held_reg;
    awaddr_next = awaddr_reg;
    w_held_next = w_held_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg && !s_axi_bready;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg && !s_axi_rready;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    kill_all = recal_pulse; // see (R14)
    wv = '0;
    lim = '0;
    cdp = '0;
    wch = awaddr_reg[`DSAU_CHAN_BIT];
    rch = s_axi_araddr[`DSAU_CHAN_BIT];
    if (s_axi_awvalid && !aw_held_reg) begin
      aw_held_next = 1'b1;
      awaddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_held_reg) begin
      w_held_next = 1'b1;
      wdata_next = s_axi_wdata;
      wstrb_next = s_axi_wstrb;
    end
    wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
    if (wr_fire) begin
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = `DSAU_RESP_OKAY;
      lim = cfg_reg[wch].total_sel ? `DSAU_TOTAL_MAX : `DSAU_RATE_MAX; // see (R16)
      case (awaddr_reg)
        `DSAU_CTRL0_OFS, `DSAU_CTRL1_OFS: begin
          wv = merge(ctrl_word(cfg_reg[wch]), wdata_reg, wstrb_reg); // see (R01)
          if (wv[`DSAU_TYPE_BIT] != cfg_reg[wch].total_sel) begin
            cfg_next[wch] = default_cfg(wv[`DSAU_TYPE_BIT]); // see (R15)
            kill_all = 1'b1; // see (R14)
          end else begin
            cfg_next[wch].alarm_enable = wv[`DSAU_EN_BIT]; // see (R13)
            cfg_next[wch].high_low_select = wv[`DSAU_HL_BIT];
            cfg_next[wch].nc_sel = wv[`DSAU_NC_BIT];
          end
        end
        `DSAU_SP0_OFS, `DSAU_SP1_OFS: begin
          wv = clamp(merge({5'h00, cfg_reg[wch].setpoint}, wdata_reg, wstrb_reg), lim);
          cfg_next[wch].setpoint = wv[`DSAU_SP_W-1:0]; // see (R16)
        end
        `DSAU_HYS0_OFS, `DSAU_HYS1_OFS: begin
          wv = clamp(merge({12'h000, cfg_reg[wch].hysteresis_band}, wdata_reg, wstrb_reg),
                     `DSAU_RATE_MAX);
          cfg_next[wch].hysteresis_band = wv[`DSAU_RATE_W-1:0]; // see (R07)
        end
        `DSAU_DLY0_OFS, `DSAU_DLY1_OFS: begin
          wv = clamp(merge({20'h00000, cfg_reg[wch].activation_delay}, wdata_reg, wstrb_reg),
                     `DSAU_TIME_MAX);
          cfg_next[wch].activation_delay = wv[`DSAU_TIME_W-1:0]; // see (R08)
        end
        `DSAU_SIL0_OFS, `DSAU_SIL1_OFS: begin
          wv = clamp(merge({20'h00000, cfg_reg[wch].silence_time}, wdata_reg, wstrb_reg),
                     `DSAU_TIME_MAX);
          cfg_next[wch].silence_time = wv[`DSAU_TIME_W-1:0]; // see (R18)
        end
        `DSAU_DP_OFS: begin
          wv = merge({26'h0000000, dp_reg}, wdata_reg, wstrb_reg);
          dp_next = wv[2*`DSAU_DP_W-1:0];
        end
        `DSAU_STAT_OFS: begin
          // Status is read-only; a write is accepted and has no effect.
        end
        default: begin
          bresp_next = `DSAU_RESP_SLVERR;
        end
      endcase
    end
    // Recalibration overrides an enable written in the same cycle.
    if (kill_all) begin
      cfg_next[0].alarm_enable = 1'b0; // see (R14)
      cfg_next[1].alarm_enable = 1'b0;
    end
    if (s_axi_arvalid && !rvalid_reg) begin
      rvalid_next = 1'b1;
      rresp_next = `DSAU_RESP_OKAY;
      rdata_next = '0;
      cdp = cfg_reg[rch].total_sel ? dp_reg[`DSAU_TDP_LSB +: `DSAU_DP_W] :
                                     dp_reg[0 +: `DSAU_DP_W];
      case (s_axi_araddr)
        `DSAU_CTRL0_OFS, `DSAU_CTRL1_OFS: begin
          rdata_next = ctrl_word(cfg_reg[rch]);
          rdata_next[`DSAU_CDP_LSB +: `DSAU_DP_W] = cdp; // see (R17)
        end
        `DSAU_SP0_OFS, `DSAU_SP1_OFS: begin
          rdata_next = {5'h00, cfg_reg[rch].setpoint};
        end
        `DSAU_HYS0_OFS, `DSAU_HYS1_OFS: begin
          rdata_next = {12'h000, cfg_reg[rch].hysteresis_band};
        end
        `DSAU_DLY0_OFS, `DSAU_DLY1_OFS: begin
          rdata_next = {20'h00000, cfg_reg[rch].activation_delay};
        end
        `DSAU_SIL0_OFS, `DSAU_SIL1_OFS: begin
          rdata_next = {20'h00000, cfg_reg[rch].silence_time};
        end
        `DSAU_STAT_OFS: begin
          rdata_next[0 +: `DSAU_STAT_W] = stat_w[0]; // see (R12)
          rdata_next[`DSAU_STAT1_LSB +: `DSAU_STAT_W] = stat_w[1];
        end
        `DSAU_DP_OFS: begin
          rdata_next = {26'h0000000, dp_reg};
        end
        default: begin
          rresp_next = `DSAU_RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_reg[0] <= default_cfg(1'b0);
      cfg_reg[1] <= default_cfg(1'b0);
      dp_reg <= '0;
      aw_held_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      w_held_reg <= 1'b0;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `DSAU_RESP_OKAY;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= `DSAU_RESP_OKAY;
    end else begin
      cfg_reg <= cfg_next;
      dp_reg <= dp_next;
      aw_held_reg <= aw_held_next;
      awaddr_reg <= awaddr_next;
      w_held_reg <= w_held_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  // ==========================================================
  // Alarm channels
  for (genvar g = 0; g < 2; g++) begin : g_chan
    dsau_channel u_chan (
      .aclk(aclk),
      .aresetn(aresetn),
      .cfg(cfg_reg[g]),
      .rate_value(rate_value),
      .total_value(total_snap_reg),
      .sec_tick(sec_tick),
      .flash_phase(flash_reg),
      .accept_pulse(accept_pulse),
      .stat(stat_w[g])
    ); // see (R01)
    assign alarm_switch_closed[g] = stat_w[g].switch_closed;
    assign annunciator_on[g] = stat_w[g].annunciator; // see (R12)
  end

endmodule // dsau_top

/* File: tb/dsau_panel_model.sv */
// Front-panel operator and alarm loop wiring model for the dual setpoint alarm unit.
`timescale 1ns/100ps

module dsau_panel_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic press,
  input wire logic [1:0] alarm_switch_closed,
  output logic accept_pulse,
  output logic [1:0] loop_open
);
  logic press_reg;

  // ==========================================================
  // Accept button and alarm loop
  // One press gives one single-cycle pulse, however long the button is held.
  always_ff @(posedge aclk) begin
    press_reg <= press & aresetn;
    accept_pulse <= press & !press_reg & aresetn;
  end

  // An open loop reads as alarm, so a dead unit is seen as alarmed too.
  assign loop_open = ~alarm_switch_closed;
endmodule // dsau_panel_model

/* File: tb/dsau_top_chk.sv */
// Concurrent checks on the ports of the dual setpoint alarm unit.
`timescale 1ns/100ps

module dsau_top_chk #(
  parameter int HALF_SEC_CYCLES = 20
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic recal_pulse,
  input wire logic [1:0] alarm_switch_closed,
  input wire logic [1:0] annunciator_on
);
  // ==========================================================
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_reset_quiet: assert property (
    $rose(aresetn) |-> alarm_switch_closed == 2'h0 && annunciator_on == 2'h0)
    else $error("outputs not quiet after reset");
  a_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rdata_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data pending");
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_aw_held: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("second write address taken");
  a_unmapped_err: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h2C
    |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_recal_dark: assert property (
    recal_pulse |-> ##[1:4] annunciator_on == 2'h0)
    else $error("annunciator lit after recalibration");
endmodule // dsau_top_chk

bind dsau_top dsau_top_chk #(.HALF_SEC_CYCLES(HALF_SEC_CYCLES)) i_chk (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .recal_pulse, .alarm_switch_closed, .annunciator_on
);

/* File: tb/test_dsau_top.sv */
// Self-checking testbench for the dual setpoint alarm unit.
`timescale 1ns/100ps
`include "dsau_consts.svh"

module test_dsau_top;
  localparam int H = 20;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic [19:0] rate_value = 20'h0;
  logic [26:0] total_value = 27'h0;
  logic recal_pulse = 1'b0;
  logic accept_pulse;
  logic press = 1'b0;
  logic [1:0] alarm_switch_closed;
  logic [1:0] annunciator_on;
  logic [1:0] loop_open;
  logic [31:0] d;
  logic [1:0] r;
  int cyc = 0;
  int t0;
  int k;
  int n_mismatch = 0;
  int n_compared = 0;

  dsau_top #(.HALF_SEC_CYCLES(H)) i_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rate_value, .total_value,
    .recal_pulse, .accept_pulse, .alarm_switch_closed, .annunciator_on
  );
  dsau_panel_model i_panel (
    .aclk, .aresetn, .press, .alarm_switch_closed, .accept_pulse, .loop_open
  );

  initial begin
    forever #25 aclk = ~aclk;
  end
  always @(posedge aclk) cyc <= cyc + 1;

  // ==========================================================
  // Bus tasks and comparison
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Values read just after a rising edge are those the design sampled at it,
  // because its registers only update later in that time step.
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic aw_ok = 1'b0;
    logic w_ok = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end while (!(aw_ok && w_ok));
    do @(posedge aclk); while (!s_axi_bvalid);
    chk(s_axi_bresp, `DSAU_RESP_OKAY);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    v = s_axi_rdata;
    e = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rd(a, d, r);
    chk(d, e);
  endtask

  // Polls a channel's status field under a bounded count of reads.
  task automatic wst(input int sh, input logic [4:0] m, input logic [4:0] e);
    int i = 0;
    do begin
      rd(`DSAU_STAT_OFS, d, r);
      i++;
    end while ((d[sh+:5] & m) !== e && i < 300);
    chk(d[sh+:5] & m, e);
  endtask

  task automatic close_out();
    if (n_mismatch == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ==========================================================
  // Tests
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(`DSAU_CTRL0_OFS, 32'hC);
    rchk(`DSAU_STAT_OFS, 32'h808);
    chk(alarm_switch_closed, 2'h3);
    rd(8'h30, d, r);
    chk(r, `DSAU_RESP_SLVERR);
    chk(d, 32'h0);
    wr(`DSAU_SP0_OFS, 32'hFFFFFFFF);
    rchk(`DSAU_SP0_OFS, `DSAU_RATE_MAX);
    wr(`DSAU_SP0_OFS, 32'h64);
    wr(`DSAU_HYS0_OFS, 32'hA);
    wr(`DSAU_CTRL0_OFS, 32'hD);
    rate_value <= 20'h64;
    wst(0, 5'h1F, 5'h16);
    chk(loop_open, 2'h1);
    rate_value <= 20'h5A;
    repeat (10) @(posedge aclk);
    rchk(`DSAU_STAT_OFS, 32'h816);
    rate_value <= 20'h59;
    wst(0, 5'h1F, 5'h08);
    wr(`DSAU_CTRL0_OFS, 32'hC);
    rate_value <= 20'h64;
    repeat (10) @(posedge aclk);
    rchk(`DSAU_STAT_OFS, 32'h808);
    rchk(`DSAU_SP0_OFS, 32'h64);
    // Only byte lane one is enabled, so the low byte of the data must be dropped.
    s_axi_wstrb <= 4'h2;
    wr(`DSAU_DLY0_OFS, 32'hA03);
    rchk(`DSAU_DLY0_OFS, 32'hA00);
    s_axi_wstrb <= 4'hF;
    wr(`DSAU_DLY0_OFS, 32'h2);
    wr(`DSAU_CTRL0_OFS, 32'hD);
    wst(0, 5'h1B, 5'h19);
    k = 0;
    repeat (2 * H) begin
      @(posedge aclk);
      k += annunciator_on[0];
    end
    chk(k >= H - 1 && k <= H + 1, 1);
    rate_value <= 20'h0;
    wst(0, 5'h1F, 5'h08);
    chk(loop_open, 2'h0);
    rate_value <= 20'h64;
    t0 = cyc;
    wst(0, 5'h03, 5'h02);
    chk(cyc - t0 >= 4 * H && cyc - t0 <= 6 * H + 20, 1);
    wr(`DSAU_SIL0_OFS, 32'h1);
    press <= 1'b1;
    @(posedge aclk);
    press <= 1'b0;
    wst(0, 5'h1B, 5'h1B);
    wst(0, 5'h1B, 5'h12);
    wr(`DSAU_CTRL0_OFS, 32'h5);
    wst(0, 5'h1F, 5'h1E);
    wr(`DSAU_DP_OFS, 32'h1A);
    total_value <= 27'h28;
    wr(`DSAU_CTRL1_OFS, 32'h2);
    rchk(`DSAU_CTRL0_OFS, 32'h204);
    rchk(`DSAU_CTRL1_OFS, 32'h30E);
    wr(`DSAU_SP1_OFS, 32'hFFFFFFFF);
    rchk(`DSAU_SP1_OFS, `DSAU_TOTAL_MAX);
    wr(`DSAU_SP1_OFS, 32'h32);
    wr(`DSAU_HYS1_OFS, 32'h32);
    wr(`DSAU_CTRL1_OFS, 32'h3);
    t0 = cyc;
    wst(8, 5'h1F, 5'h1E);
    chk(cyc - t0 <= H + 12, 1);
    chk(annunciator_on, 2'h2);
    total_value <= 27'h33;
    wst(8, 5'h1F, 5'h00);
    recal_pulse <= 1'b1;
    @(posedge aclk);
    recal_pulse <= 1'b0;
    rchk(`DSAU_CTRL1_OFS, 32'h302);
    close_out();
  end

  initial begin
    repeat (40000) @(posedge aclk);
    n_mismatch++;
    close_out();
  end
endmodule // test_dsau_top
